// ### common/boost_ctrl_pkg.sv
// Package for the boost switch control logic: register map, timing counts,
// comparator bundles and state encodings.
// Assumes a 100 MHz hclk and an AHB-Lite master with single word transfers.
package boost_ctrl_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Fixed delays in ns and their cycle counts.
  localparam int unsigned DEAD_DELAY_NS     = 40;
  localparam int unsigned SYNC_DELAY_NS     = 400;
  localparam int unsigned OFF_SHORT_NS      = 400;
  localparam int unsigned OFF_LONG_NS       = 750;
  localparam int unsigned ONE_SHOT_NS       = 350;
  localparam int unsigned DEAD_CYC =
    (DEAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_CYC  = SYNC_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned OFF_SHORT_CYC =
    (OFF_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFF_LONG_CYC =
    (OFF_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ONE_SHOT_CYC =
    (ONE_SHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;

  // Register byte addresses.
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] PERIOD_ADDR = 8'h08;

  // Control register fields.
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] PERIOD_RESET = 32'h0000_00C8;

  // Comparator outputs from the analog front end, raw and asynchronous.
  typedef struct packed {
    logic line_uv_ok;
    logic bias_uv_ok;
    logic ramp_low;
    logic ramp_above_ref;
    logic ramp_held_low;
    logic pwm_trip;
    logic cur_limit;
    logic zc_rise;
    logic zc_fall;
    logic hs_gate_low;
    logic ls_gate_low;
    logic sync_rise;
    logic sync_fall;
    logic bypass;
    logic bias_good;
    logic over_temp;
    logic mode_fcm;
    logic phase_opt_hi;
    logic fb_follower;
  } comp_t;

  localparam int unsigned COMP_W = $bits(comp_t);

  // Analog enables driven by the logic.
  typedef struct packed {
    logic ramp_source_en;
    logic ramp_pulldown;
    logic ref_select_ramp;
    logic charge_pump_en;
    logic bias_reg_en;
    logic disconnect_en;
  } analog_ctl_t;

  typedef enum logic [4:0] {
    ST_OFF       = 5'b00001,
    ST_DISCHARGE = 5'b00010,
    ST_RAMP      = 5'b00100,
    ST_RUN       = 5'b01000,
    ST_SHUTDOWN  = 5'b10000
  } ss_state_t;

endpackage

// ### design/comp_sync.sv
// Two-flop synchroniser for the comparator bundle.
// Assumes every bit is an independent asynchronous level.
`timescale 1ns/10ps
`default_nettype none
module comp_sync
  import boost_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // Levels
  input  wire boost_ctrl_pkg::comp_t raw,
  output boost_ctrl_pkg::comp_t      synced
);
  comp_t stage1_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1_reg <= '0;
      synced     <= '0;
    end
    else
    begin
      stage1_reg <= raw;
      synced     <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// ### design/boost_switch_control_logic.sv
// Control logic of a synchronous boost controller: soft-start sequencing,
// gate interlock, current limit, zero-current detection and sync handling.
// Assumes analog comparators supply levels and an AHB-Lite master drives regs.
//
// Notes on behaviour
// - Ramp source needs line above threshold and bias undervoltage clear.
// - Each soft-start holds ramp pulldown until ramp under 25 mV.
// - Feedback follows lower of ramp and 1.2 V reference.
// - Ramp held low from outside stops switching.
// - Low side waits for high side discharge plus delay.
// - High side waits for low side discharge plus delay.
// - Input at or above target keeps high side on.
// - Charge pump needs line up and bias undervoltage clear.
// - Sense above 75 mV ends the low-side pulse at once; the soft-start one-shot ignores the limit and runs its full 350 ns.
// - Low-side pulses skipped while current stays above limit; the soft-start one-shot starts without checking the limit.
// - Sync pulse needs both rising and falling thresholds.
// - Low side starts about 400 ns after sync rise.
// - Oscillator at twice or equal to switching rate by strapping.
// - Low side forced off 400 ns each cycle, 750 ns at low bias.
// - At about 165 C, drivers, disconnect switch and bias reg off.
// - Mode input high selects forced continuous, reverse current unlimited.
// - Diode emulation: high side only if sense exceeded 7 mV.
// - Diode emulation: sense below 6 mV latches high side off.
// - Diode emulation forced until ramp over 1.2 V and next trip.
// - No low-side pulse in soft-start gives one 350 ns pulse.
// - Power-on feedback strap latches follower until power cycle.
// - Leader with option high: no clock out, sync rate.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module boost_switch_control_logic
(
  // Clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [7:0]                  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // Analog front end
  input  wire boost_ctrl_pkg::comp_t       comp_raw,
  output boost_ctrl_pkg::analog_ctl_t      analog_ctl,
  // Gate drives and clock out
  output logic                             high_side_gate,
  output logic                             low_side_gate,
  output logic                             phase_shifted_clock_out
);
  import boost_ctrl_pkg::*;

  comp_t       c;
  ss_state_t   state_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] period_reg;
  logic        wr_pend_reg;
  logic [7:0]  addr_reg;
  logic        follower_reg;
  logic        strap_done_reg;
  logic        sync_armed_reg;
  logic        sync_prev_reg;
  logic        sync_pulse;
  logic        osc_tick;
  logic        cycle_start;
  logic        div_reg;
  logic        ext_mode;
  logic        divide;
  logic [CNT_W-1:0] osc_cnt_reg;
  logic [CNT_W-1:0] sync_cnt_reg;
  logic        sync_wait_reg;
  logic        ls_req_reg;
  logic [CNT_W-1:0] off_cnt_reg;
  logic [CNT_W-1:0] dead_cnt_reg;
  logic [CNT_W-1:0] shot_cnt_reg;
  logic        ls_seen_reg;
  logic        fde_reg;
  logic        zc_ok_reg;
  logic        hs_latch_off_reg;
  logic        enabled;
  logic        switching;
  logic        ls_want;
  logic        hs_want;
  logic [CNT_W-1:0] off_need;

  comp_sync u_sync
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .raw     (comp_raw),
    .synced  (c)
  );

  // Register bus: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      addr_reg    <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg   <= CTRL_RESET;
      period_reg <= PERIOD_RESET;
    end
    else if (wr_pend_reg)
    begin
      if (addr_reg == CTRL_ADDR)
        ctrl_reg <= {31'h0000_0000, hwdata[CTRL_EN_BIT]};
      else if (addr_reg == PERIOD_ADDR)
        period_reg <= {24'h00_0000, hwdata[CNT_W-1:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      case (haddr)
        CTRL_ADDR:   hrdata <= ctrl_reg;
        STATUS_ADDR: hrdata <= {19'h0_0000, follower_reg, fde_reg,
                                ls_seen_reg, high_side_gate, low_side_gate,
                                c.cur_limit, c.over_temp, c.bypass,
                                state_reg};
        PERIOD_ADDR: hrdata <= period_reg;
        default:     hrdata <= '0;
      endcase
    end
  end

  // Strap is caught once after reset release; stays until power cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      follower_reg   <= 1'b0;
      strap_done_reg <= 1'b0;
    end
    else if (!strap_done_reg && c.bias_uv_ok)
    begin
      follower_reg   <= c.fb_follower;
      strap_done_reg <= 1'b1;
    end
  end

  // Sync detect needs falling then rising threshold crossings.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_armed_reg <= 1'b0;
      sync_prev_reg  <= 1'b0;
    end
    else
    begin
      sync_prev_reg <= c.sync_rise;
      if (c.sync_fall)
        sync_armed_reg <= 1'b1;
      else if (sync_pulse)
        sync_armed_reg <= 1'b0;
    end
  end
  assign sync_pulse = c.sync_rise && !sync_prev_reg && sync_armed_reg;

  // Followers and leader with option high run on the external clock only.
  assign ext_mode = follower_reg || c.phase_opt_hi;
  assign divide   = follower_reg ? c.phase_opt_hi : !c.phase_opt_hi;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      osc_cnt_reg <= '0;
    else if (sync_pulse || osc_cnt_reg >= period_reg[CNT_W-1:0])
      osc_cnt_reg <= '0;
    else
      osc_cnt_reg <= osc_cnt_reg + 1'b1;
  end
  assign osc_tick = sync_pulse ||
                    (!ext_mode && osc_cnt_reg >= period_reg[CNT_W-1:0]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= 1'b0;
    else if (osc_tick)
      div_reg <= !div_reg;
  end

  // Clock out is the divided oscillator, off when not dividing.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase_shifted_clock_out <= 1'b0;
    else
      phase_shifted_clock_out <= divide && !(c.phase_opt_hi && !follower_reg)
                                 && div_reg;
  end

  // Delay from oscillator tick to low-side start.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_wait_reg <= 1'b0;
      sync_cnt_reg  <= '0;
    end
    else if (osc_tick && (!divide || !div_reg))
    begin
      sync_wait_reg <= 1'b1;
      // Dead time is part of the sync to low-side delay.
      sync_cnt_reg  <= CNT_W'(SYNC_CYC - DEAD_CYC - 1);
    end
    else if (sync_wait_reg)
    begin
      if (sync_cnt_reg == '0)
        sync_wait_reg <= 1'b0;
      else
        sync_cnt_reg <= sync_cnt_reg - 1'b1;
    end
  end
  assign cycle_start = sync_wait_reg && sync_cnt_reg == '0;

  // Soft-start sequencer.
  assign enabled = ctrl_reg[CTRL_EN_BIT] && c.line_uv_ok && c.bias_uv_ok;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= ST_OFF;
    else if (c.over_temp)
      state_reg <= ST_SHUTDOWN;
    else
    begin
      case (state_reg)
        ST_OFF:       if (enabled) state_reg <= ST_DISCHARGE;
        ST_DISCHARGE: if (!enabled) state_reg <= ST_OFF;
                      else if (c.ramp_low) state_reg <= ST_RAMP;
        ST_RAMP:      if (!enabled) state_reg <= ST_OFF;
                      else if (c.ramp_above_ref) state_reg <= ST_RUN;
        ST_RUN:       if (!enabled) state_reg <= ST_OFF;
        ST_SHUTDOWN:  state_reg <= ST_OFF;
        default:      state_reg <= ST_OFF;
      endcase
    end
  end

  always_comb
  begin
    analog_ctl.ramp_source_en  = enabled &&
                                 (state_reg == ST_RAMP || state_reg == ST_RUN);
    analog_ctl.ramp_pulldown   = state_reg != ST_RAMP &&
                                 state_reg != ST_RUN;
    analog_ctl.ref_select_ramp = !c.ramp_above_ref;
    analog_ctl.charge_pump_en  = c.line_uv_ok && c.bias_uv_ok &&
                                 state_reg != ST_SHUTDOWN;
    analog_ctl.bias_reg_en     = state_reg != ST_SHUTDOWN;
    analog_ctl.disconnect_en   = state_reg != ST_SHUTDOWN &&
                                 state_reg != ST_OFF;
  end

  // Switching needs a running ramp not held low by the outside.
  assign switching = (state_reg == ST_RAMP || state_reg == ST_RUN) &&
                     !c.ramp_held_low && !c.bypass;

  // Forced diode emulation through start-up.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fde_reg <= 1'b1;
    else if (state_reg != ST_RUN && state_reg != ST_RAMP)
      fde_reg <= 1'b1;
    else if (c.ramp_above_ref && c.pwm_trip)
      fde_reg <= 1'b0;
  end

  // Low-side request: set at cycle start, ended by trip, limit or one-shot.
  assign off_need = c.bias_good ? CNT_W'(OFF_SHORT_CYC)
                                : CNT_W'(OFF_LONG_CYC);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ls_req_reg   <= 1'b0;
      off_cnt_reg  <= '0;
      shot_cnt_reg <= '0;
    end
    else if (shot_cnt_reg != '0 &&
             (state_reg == ST_RAMP || state_reg == ST_RUN))
    begin
      // The one-shot is timed at the gate, so dead time does not shorten it.
      if (low_side_gate)
      begin
        shot_cnt_reg <= shot_cnt_reg - 1'b1;
        ls_req_reg   <= shot_cnt_reg != CNT_W'(1);
        if (shot_cnt_reg == CNT_W'(1))
          off_cnt_reg <= off_need;
      end
    end
    else if (state_reg == ST_RAMP && c.ramp_above_ref && !ls_seen_reg
             && !c.ramp_held_low)
    begin
      ls_req_reg   <= 1'b1;
      shot_cnt_reg <= CNT_W'(ONE_SHOT_CYC - 1);
    end
    else if (!switching)
    begin
      ls_req_reg   <= 1'b0;
      off_cnt_reg  <= '0;
      shot_cnt_reg <= '0;
    end
    else if (ls_req_reg && (c.cur_limit || c.pwm_trip))
    begin
      ls_req_reg  <= 1'b0;
      off_cnt_reg <= off_need;
    end
    else if (ls_req_reg && off_cnt_reg != '0)
      ls_req_reg <= 1'b0;
    else
    begin
      if (off_cnt_reg != '0)
        off_cnt_reg <= off_cnt_reg - 1'b1;
      if (cycle_start && !c.cur_limit && off_cnt_reg == '0)
        ls_req_reg <= 1'b1;
    end
  end

  // One-shot is only wanted when soft-start saw no low-side pulse.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ls_seen_reg <= 1'b0;
    else if (state_reg == ST_DISCHARGE || state_reg == ST_OFF)
      ls_seen_reg <= 1'b0;
    else if (low_side_gate)
      ls_seen_reg <= 1'b1;
  end

  // Zero-current detection in diode emulation.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      zc_ok_reg        <= 1'b0;
      hs_latch_off_reg <= 1'b0;
    end
    else
    begin
      if (cycle_start)
      begin
        zc_ok_reg        <= 1'b0;
        hs_latch_off_reg <= 1'b0;
      end
      if (low_side_gate && c.zc_rise)
        zc_ok_reg <= 1'b1;
      if (high_side_gate && c.zc_fall)
        hs_latch_off_reg <= 1'b1;
    end
  end

  // Diode emulation applies unless forced continuous and start-up is over.
  assign ls_want = ls_req_reg;
  assign hs_want = c.bypass ? state_reg == ST_RUN || state_reg == ST_RAMP
                 : switching && !ls_req_reg &&
                   ((c.mode_fcm && !fde_reg) ||
                    (zc_ok_reg && !hs_latch_off_reg));

  // Adaptive dead time: the other gate must read low, then a counted delay.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      high_side_gate <= 1'b0;
      low_side_gate  <= 1'b0;
      dead_cnt_reg   <= '0;
    end
    else if (state_reg == ST_SHUTDOWN || c.over_temp)
    begin
      high_side_gate <= 1'b0;
      low_side_gate  <= 1'b0;
      dead_cnt_reg   <= '0;
    end
    else if (ls_want)
    begin
      high_side_gate <= 1'b0;
      if (low_side_gate)
        dead_cnt_reg <= '0;
      else if (!high_side_gate && c.hs_gate_low)
      begin
        if (dead_cnt_reg == CNT_W'(DEAD_CYC))
          low_side_gate <= 1'b1;
        else
          dead_cnt_reg <= dead_cnt_reg + 1'b1;
      end
      else
        dead_cnt_reg <= '0;
    end
    else if (hs_want)
    begin
      low_side_gate <= 1'b0;
      if (high_side_gate)
        dead_cnt_reg <= '0;
      else if (!low_side_gate && c.ls_gate_low)
      begin
        if (dead_cnt_reg == CNT_W'(DEAD_CYC))
          high_side_gate <= 1'b1;
        else
          dead_cnt_reg <= dead_cnt_reg + 1'b1;
      end
      else
        dead_cnt_reg <= '0;
    end
    else
    begin
      high_side_gate <= 1'b0;
      low_side_gate  <= 1'b0;
      dead_cnt_reg   <= '0;
    end
  end
endmodule
`default_nettype wire

// ### verification/boost_ctrl_checker.sv
// Concurrent checks on the gate drives and analog enables of the controller.
// Assumes comparator levels reach the logic two flops late.
`timescale 1ns/10ps
`default_nettype none
module boost_ctrl_checker
  import boost_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic                        hclk,
  input wire logic                        hresetn,
  // Observed ports
  input wire boost_ctrl_pkg::comp_t       comp_raw,
  input wire boost_ctrl_pkg::analog_ctl_t analog_ctl,
  input wire logic                        high_side_gate,
  input wire logic                        low_side_gate,
  input wire logic                        phase_shifted_clock_out
);
  logic [7:0] hs_off_reg;
  logic [7:0] ls_off_reg;
  logic [3:0] cl_reg;
  logic [3:0] ot_reg;
  logic [3:0] line_reg;
  logic [3:0] held_reg;
  logic [3:0] byp_reg;
  logic [3:0] opt_reg;

  // Counts saturate, so a long wait never wraps into a false short one.
  function automatic logic [3:0] sat(input logic c, input logic [3:0] v);
    return c ? v + {3'h0, v != 4'hF} : 4'h0;
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hs_off_reg <= 8'hFF;
      ls_off_reg <= 8'hFF;
      {cl_reg, ot_reg, line_reg, held_reg, byp_reg, opt_reg} <= '0;
    end
    else
    begin
      hs_off_reg <= high_side_gate ? 8'h00 : hs_off_reg + {7'h00, hs_off_reg != 8'hFF};
      ls_off_reg <= low_side_gate ? 8'h00 : ls_off_reg + {7'h00, ls_off_reg != 8'hFF};
      cl_reg <= sat(comp_raw.cur_limit, cl_reg);
      ot_reg <= sat(comp_raw.over_temp, ot_reg);
      line_reg <= sat(!comp_raw.line_uv_ok, line_reg);
      held_reg <= sat(comp_raw.ramp_held_low, held_reg);
      byp_reg <= sat(comp_raw.bypass, byp_reg);
      opt_reg <= sat(comp_raw.phase_opt_hi && !comp_raw.fb_follower, opt_reg);
    end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_gates_exclusive: assert property (!(high_side_gate && low_side_gate))
    else $error("both gate drives on");
  a_low_dead_time: assert property ($rose(low_side_gate) |-> hs_off_reg >= DEAD_CYC)
    else $error("low side rose without dead time");
  a_high_dead_time: assert property ($rose(high_side_gate) |-> ls_off_reg >= DEAD_CYC)
    else $error("high side rose without dead time");
  a_min_off_time: assert property ($rose(low_side_gate) |-> ls_off_reg >= OFF_SHORT_CYC)
    else $error("low side off time too short");
  a_limit_ends_pulse: assert property (comp_raw.cur_limit && low_side_gate |-> ##[1:4] !low_side_gate)
    else $error("current limit did not end pulse");
  a_limit_skips_pulse: assert property (cl_reg >= 4 |-> !$rose(low_side_gate))
    else $error("pulse started in current limit");
  a_thermal_shutdown: assert property (ot_reg >= 5 |-> !high_side_gate && !low_side_gate && !analog_ctl.bias_reg_en && !analog_ctl.disconnect_en)
    else $error("drives or bias on in over temperature");
  a_line_gates_enables: assert property (line_reg >= 5 |-> !analog_ctl.ramp_source_en && !analog_ctl.charge_pump_en)
    else $error("ramp source or pump on with line low");
  a_held_ramp_stops: assert property (held_reg >= 5 |-> !low_side_gate)
    else $error("switching while ramp held low");
  a_bypass_no_low: assert property (byp_reg >= 5 |-> !low_side_gate)
    else $error("low side on in bypass");
  a_clock_out_off: assert property (opt_reg >= 5 |-> !phase_shifted_clock_out)
    else $error("clock out active with option high");

  c_low_pulse: cover property ($rose(low_side_gate));
  c_high_pulse: cover property ($rose(high_side_gate));
  c_limit_cut: cover property (comp_raw.cur_limit && low_side_gate);
  c_shutdown: cover property (ot_reg >= 5);
endmodule
bind boost_switch_control_logic boost_ctrl_checker u_chk (.hclk(hclk),
  .hresetn(hresetn), .comp_raw(comp_raw), .analog_ctl(analog_ctl),
  .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
  .phase_shifted_clock_out(phase_shifted_clock_out));
`default_nettype wire

// ### verification/power_stage_model.sv
// Far side model: gate discharge feedback, current sense and sync source.
// Assumes the bench sets every other comparator level through levels.
`timescale 1ns/10ps
`default_nettype none
module power_stage_model
  import boost_ctrl_pkg::*;
#(
  parameter int unsigned SYNC_PER = 180
)
(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // Bench controls
  input  wire boost_ctrl_pkg::comp_t levels,
  input  wire logic [7:0]            trip_cyc,
  input  wire logic                  limit_mode,
  input  wire logic                  zc_en,
  input  wire logic                  sync_en,
  // Gate drives
  input  wire logic                  high_side_gate,
  input  wire logic                  low_side_gate,
  // Comparator view
  output boost_ctrl_pkg::comp_t      comp_raw
);
  logic [7:0] on_reg;
  logic [7:0] sync_reg;
  logic       hs_low_reg;
  logic       ls_low_reg;
  logic       trip;
  logic       sync_hi;

  // Gate charge bleeds away a cycle after the drive drops.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hs_low_reg <= 1'h1;
      ls_low_reg <= 1'h1;
      on_reg <= 8'h00;
    end
    else
    begin
      hs_low_reg <= !high_side_gate;
      ls_low_reg <= !low_side_gate;
      on_reg <= low_side_gate ? on_reg + {7'h00, on_reg != 8'hFF} : 8'h00;
    end

  // The sync line rests low when off and runs without gaps when on.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      sync_reg <= 8'h00;
    else if (!sync_en || sync_reg == 8'(SYNC_PER - 1))
      sync_reg <= 8'h00;
    else
      sync_reg <= sync_reg + 8'h01;

  assign sync_hi = sync_en && (sync_reg < 8'(SYNC_PER / 2));
  assign trip = (trip_cyc != 8'h00) && (on_reg >= trip_cyc);

  // The ramp levels only ever come from the bench: low, above reference and held low.
  always_comb
  begin
    comp_raw = levels;
    comp_raw.hs_gate_low = hs_low_reg;
    comp_raw.ls_gate_low = ls_low_reg;
    comp_raw.pwm_trip = levels.pwm_trip | (!limit_mode && trip);
    comp_raw.cur_limit = levels.cur_limit | (limit_mode && trip);
    comp_raw.zc_rise = zc_en && low_side_gate;
    comp_raw.zc_fall = !zc_en;
    comp_raw.sync_rise = sync_hi;
    comp_raw.sync_fall = !sync_hi;
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the boost switch control logic.
// Assumes the power stage model and the checker bind are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import boost_ctrl_pkg::*;
  localparam int LIMIT = 30000;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hs, ls, sclk;
  logic limit_mode, zc_en, sync_en, sync_d, low_d, high_d;
  logic [7:0] haddr, trip_cyc;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, got;
  comp_t lvl, comp;
  analog_ctl_t actl;
  int failures, compares, cyc, sync_at, rise_at, delay, gap, width;
  int ls_rises, hs_rises, n;

  boost_switch_control_logic DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .comp_raw(comp), .analog_ctl(actl),
    .high_side_gate(hs), .low_side_gate(ls), .phase_shifted_clock_out(sclk));
  power_stage_model stage (.hclk(hclk), .hresetn(hresetn), .levels(lvl),
    .trip_cyc(trip_cyc), .limit_mode(limit_mode), .zc_en(zc_en),
    .sync_en(sync_en), .high_side_gate(hs), .low_side_gate(ls),
    .comp_raw(comp));

  initial
  begin
    hclk = 1'h0;
    forever
      #5 hclk = ~hclk;
  end

  task automatic tally_and_finish();
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single word transfer; called just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    {hsel, haddr, htrans, hwrite, hsize} <= {1'h1, a, 2'h2, w, 3'h2};
    @(posedge hclk);
    while (hreadyout !== 1'h1)
      @(posedge hclk);
    {htrans, hsel, hwdata} <= {2'h0, 1'h0, wd};
    @(posedge hclk);
    while (hreadyout !== 1'h1)
      @(posedge hclk);
    got = hrdata;
  endtask

  task automatic check_state(input ss_state_t s);
    bus(1'h0, STATUS_ADDR, 32'h0);
    check(32'(got[4:0]), 32'(s));
  endtask

  task automatic wait_low(input int k);
    int t;
    t = ls_rises + k;
    repeat (3000)
      if (ls_rises < t)
        @(posedge hclk);
    check(32'(ls_rises >= t), 32'h1);
  endtask

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    sync_d <= comp.sync_rise;
    low_d <= ls;
    high_d <= hs;
    if (comp.sync_rise && !sync_d)
      sync_at <= cyc;
    if (ls && !low_d)
    begin
      ls_rises <= ls_rises + 1;
      delay <= cyc - sync_at;
      gap <= cyc - rise_at;
      rise_at <= cyc;
      width <= 1;
    end
    else if (ls)
      width <= width + 1;
    if (hs && !high_d)
      hs_rises <= hs_rises + 1;
    if (cyc == LIMIT)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    hresetn = 1'h0;
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    {limit_mode, zc_en, sync_en, trip_cyc} = '0;
    lvl = '0;
    lvl.bias_good = 1'h1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, CTRL_ADDR, 32'h0);
    check(got, CTRL_RESET);
    check(32'(hresp), 32'h0);
    bus(1'h0, PERIOD_ADDR, 32'h0);
    check(got, PERIOD_RESET);
    bus(1'h1, 8'h0C, 32'hFFFF_FFFF);
    bus(1'h0, 8'h0C, 32'h0);
    check(got, 32'h0);
    check_state(ST_OFF);
    lvl.line_uv_ok <= 1'h1;
    lvl.bias_uv_ok <= 1'h1;
    lvl.cur_limit <= 1'h1;
    bus(1'h1, CTRL_ADDR, 32'h1);
    repeat (8) @(posedge hclk);
    check_state(ST_DISCHARGE);
    check(32'(actl.ramp_pulldown), 32'h1);
    check(32'(actl.charge_pump_en), 32'h1);
    lvl.ramp_low <= 1'h1;
    repeat (8) @(posedge hclk);
    check_state(ST_RAMP);
    check(32'(actl.ramp_pulldown), 32'h0);
    check(32'(actl.ramp_source_en), 32'h1);
    check(32'(actl.ref_select_ramp), 32'h1);
    repeat (600) @(posedge hclk);
    check(32'(ls_rises), 32'h0);
    lvl.cur_limit <= 1'h0;
    lvl.ramp_low <= 1'h0;
    lvl.ramp_above_ref <= 1'h1;
    wait_low(1);
    repeat (50) @(posedge hclk);
    check(32'(width), 32'(ONE_SHOT_CYC));
    check_state(ST_RUN);
    check(32'(actl.ref_select_ramp), 32'h0);
    trip_cyc <= 8'h1E;
    sync_en <= 1'h1;
    wait_low(4);
    check(32'(delay >= SYNC_CYC && delay <= SYNC_CYC + 5), 32'h1);
    check(32'(gap), 32'h168);
    check(32'(hs_rises), 32'h0);
    zc_en <= 1'h1;
    wait_low(3);
    check(32'(hs_rises > 0), 32'h1);
    n = hs_rises;
    zc_en <= 1'h0;
    lvl.mode_fcm <= 1'h1;
    wait_low(3);
    check(32'(hs_rises > n), 32'h1);
    limit_mode <= 1'h1;
    wait_low(2);
    repeat (40) @(posedge hclk);
    check(32'(width <= 36), 32'h1);
    limit_mode <= 1'h0;
    lvl.bypass <= 1'h1;
    repeat (30) @(posedge hclk);
    check({30'h0, hs, ls}, 32'h2);
    lvl.bypass <= 1'h0;
    lvl.ramp_held_low <= 1'h1;
    repeat (6) @(posedge hclk);
    n = ls_rises;
    repeat (800) @(posedge hclk);
    check(32'(ls_rises - n), 32'h0);
    lvl.ramp_held_low <= 1'h0;
    lvl.phase_opt_hi <= 1'h1;
    repeat (20) @(posedge hclk);
    check(32'(sclk), 32'h0);
    lvl.line_uv_ok <= 1'h0;
    repeat (10) @(posedge hclk);
    check(32'(actl.charge_pump_en), 32'h0);
    check(32'(actl.ramp_source_en), 32'h0);
    lvl.line_uv_ok <= 1'h1;
    lvl.over_temp <= 1'h1;
    repeat (10) @(posedge hclk);
    check({29'h0, hs, ls, actl.bias_reg_en}, 32'h0);
    check_state(ST_SHUTDOWN);
    tally_and_finish();
  end
endmodule
`default_nettype wire
